// ===== smpb_builder.sv
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - channel word: bits 31-18 reserved, type at 17-16, counter 15-0.
// - whole-message body uses type 00.
// - complete body counter holds number of messages placed.
// - segment type: 01 first, 11 middle, 10 final.
// - segment counter starts at 1, advances by one per packet.
// - a long message is limited to 4 GBytes total.
// - 12-byte header per message: time low, time high, id word.
// - default time is 48-bit relative counter, top 16 bits zero.
// - flag bit 6 selects absolute time, format from flag bits 2-3; the code never decodes bits 2-3.
// - id bit 31 set when data corruption reported.
// - id bit 30 set when protocol fault reported.
// - id bits 29-16 hold subchannel number, zero first.
// - id bits 15-0 hold message byte length.
// - a message or segment never exceeds 64K bytes.
// - body form chosen per packet: complete or one segment.
// - bytes packed two per word, low first, odd count padded.
module smpb_builder #(
    parameter int MAX_MSGS = 16
) (
    input  wire logic               ref_clk,
    input  wire logic               reset,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    output logic                    irq,
    input  wire logic [7:0]         packet_flags,
    input  wire logic               start_valid,
    output logic                    start_ready,
    input  wire logic               start_segmented,
    input  wire logic [1:0]         start_seg_pos,
    input  wire logic [15:0]        start_msg_count,
    input  wire logic               msg_valid,
    output logic                    msg_ready,
    input  wire smpb_pkg::smpb_msg_t msg_info,
    input  wire logic               byte_valid,
    output logic                    byte_ready,
    input  wire logic [7:0]         byte_data,
    output smpb_pkg::smpb_word_t    out_word,
    output logic                    out_valid,
    input  wire logic               out_ready
);
    if (MAX_MSGS < 1 || MAX_MSGS > 65535) begin : g_bad_max_msgs
        $error("MAX_MSGS out of range");
    end

    smpb_pkg::smpb_state_t st_reg, st_next;
    logic [31:0] csw_reg, csw_next;
    logic [15:0] msgs_left_reg, msgs_left_next;
    logic [15:0] hdr_cnt_reg, hdr_cnt_next;
    logic [2:0]  hw_idx_reg, hw_idx_next;
    logic [31:0] hdr_w_reg [3], hdr_w_next [3];
    logic [15:0] bytes_left_reg, bytes_left_next;
    logic        have_lo_reg, have_lo_next;
    logic [7:0]  lo_byte_reg, lo_byte_next;
    logic [15:0] seg_num_reg, seg_num_next;
    logic [31:0] long_bytes_reg, long_bytes_next;
    logic        long_open_reg, long_open_next;
    smpb_pkg::smpb_word_t out_reg, out_next;
    logic        ov_reg, ov_next;
    logic        enable_reg, enable_next;
    logic [smpb_pkg::IRQ_W-1:0] sts_reg, sts_next, mask_reg, mask_next, ev;
    logic [15:0] pkts_reg, pkts_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        can_load;
    logic [63:0] ts;
    logic [31:0] idw;
    logic [16:0] seg_total;

    assign can_load = !ov_reg || out_ready;
    assign out_word = out_reg;
    assign out_valid = ov_reg;
    assign reg_rdata = rdata_reg;
    assign irq = |(sts_reg & mask_reg);
    assign start_ready = (st_reg == smpb_pkg::ST_IDLE) && enable_reg && !ov_reg;

    always_comb begin
        ts = {smpb_pkg::TIME_ZERO_FILL, msg_info.rel_time};
        if (packet_flags[smpb_pkg::FLAG_ABS])
            ts = msg_info.abs_time;
        idw = {msg_info.data_corrupt_flag, msg_info.protocol_fault_flag,
               msg_info.subchannel, msg_info.length};
    end

    always_comb begin
        st_next = st_reg;
        csw_next = csw_reg;
        msgs_left_next = msgs_left_reg;
        hdr_cnt_next = hdr_cnt_reg;
        hw_idx_next = hw_idx_reg;
        hdr_w_next = hdr_w_reg;
        bytes_left_next = bytes_left_reg;
        have_lo_next = have_lo_reg;
        lo_byte_next = lo_byte_reg;
        seg_num_next = seg_num_reg;
        long_bytes_next = long_bytes_reg;
        long_open_next = long_open_reg;
        out_next = out_reg;
        ov_next = ov_reg && !out_ready;
        msg_ready = 1'b0;
        byte_ready = 1'b0;
        ev = '0;
        pkts_next = pkts_reg;
        seg_total = 17'h00000;
        unique case (st_reg)
            smpb_pkg::ST_IDLE: begin
                if (start_valid && start_ready) begin
                    if (start_segmented) begin
                        if (start_seg_pos == smpb_pkg::TYPE_FIRST || start_seg_pos == smpb_pkg::TYPE_COMPLETE
                            || !long_open_reg) begin
                            seg_num_next = smpb_pkg::SEG_FIRST_NUM;
                            long_bytes_next = '0;
                        end else begin
                            seg_num_next = seg_num_reg + 16'h0001;
                        end
                        long_open_next = (start_seg_pos != smpb_pkg::TYPE_LAST);
                        msgs_left_next = 16'h0001;
                        csw_next = {{smpb_pkg::CSW_RSVD_W{1'b0}}, start_seg_pos, seg_num_next};
                        if (start_seg_pos == smpb_pkg::TYPE_COMPLETE)
                            csw_next[smpb_pkg::CSW_TYPE_LSB +: smpb_pkg::CSW_TYPE_W] = smpb_pkg::TYPE_FIRST;
                    end else begin
                        msgs_left_next = (start_msg_count == 16'h0000) ? 16'h0001 :
                                         (start_msg_count > 16'(MAX_MSGS)) ? 16'(MAX_MSGS) : start_msg_count;
                        csw_next = {{smpb_pkg::CSW_RSVD_W{1'b0}}, smpb_pkg::TYPE_COMPLETE, msgs_left_next};
                    end
                    hdr_cnt_next = '0;
                    st_next = smpb_pkg::ST_CSW_LO;
                end
            end
            smpb_pkg::ST_CSW_LO: begin
                if (can_load) begin
                    out_next = '{data: csw_reg[15:0], first: 1'b1, last: 1'b0};
                    ov_next = 1'b1;
                    st_next = smpb_pkg::ST_CSW_HI;
                end
            end
            smpb_pkg::ST_CSW_HI: begin
                if (can_load) begin
                    out_next = '{data: csw_reg[31:16], first: 1'b0, last: 1'b0};
                    ov_next = 1'b1;
                    msg_ready = 1'b1;
                    st_next = smpb_pkg::ST_DONE;
                end
            end
            smpb_pkg::ST_DONE: begin
                // wait for next message header after the channel word or after a finished message
                msg_ready = 1'b1;
            end
            smpb_pkg::ST_HDR: begin
                if (can_load) begin
                    out_next = '{data: hw_idx_reg[0] ? hdr_w_reg[hw_idx_reg[2:1]][31:16]
                                                     : hdr_w_reg[hw_idx_reg[2:1]][15:0],
                                 first: 1'b0,
                                 last: 1'b0};
                    ov_next = 1'b1;
                    hw_idx_next = hw_idx_reg + 3'h1;
                    if (hw_idx_reg == 3'h5) begin
                        hdr_cnt_next = hdr_cnt_reg + 16'h0001;
                        have_lo_next = 1'b0;
                        st_next = smpb_pkg::ST_DATA;
                        if (bytes_left_reg == 16'h0000) begin
                            msgs_left_next = msgs_left_reg - 16'h0001;
                            st_next = (msgs_left_reg == 16'h0001) ? smpb_pkg::ST_IDLE : smpb_pkg::ST_DONE;
                            out_next.last = (msgs_left_reg == 16'h0001);
                            if (msgs_left_reg == 16'h0001) begin
                                ev[smpb_pkg::IRQ_PKT_DONE] = 1'b1;
                                pkts_next = pkts_reg + 16'h0001;
                            end
                        end
                    end
                end
            end
            smpb_pkg::ST_DATA: begin
                byte_ready = can_load || (!have_lo_reg && bytes_left_reg != 16'h0001);
                if (byte_valid && byte_ready) begin
                    bytes_left_next = bytes_left_reg - 16'h0001;
                    if (have_lo_reg || bytes_left_reg == 16'h0001) begin
                        out_next = '{data: have_lo_reg ? {byte_data, lo_byte_reg}
                                                       : {smpb_pkg::FILLER_BYTE, byte_data},
                                     first: 1'b0,
                                     last: 1'b0};
                        ov_next = 1'b1;
                        have_lo_next = 1'b0;
                    end else begin
                        lo_byte_next = byte_data;
                        have_lo_next = 1'b1;
                    end
                    if (bytes_left_reg == 16'h0001) begin
                        msgs_left_next = msgs_left_reg - 16'h0001;
                        out_next.last = (msgs_left_reg == 16'h0001);
                        st_next = (msgs_left_reg == 16'h0001) ? smpb_pkg::ST_IDLE : smpb_pkg::ST_DONE;
                        if (msgs_left_reg == 16'h0001) begin
                            ev[smpb_pkg::IRQ_PKT_DONE] = 1'b1;
                            pkts_next = pkts_reg + 16'h0001;
                        end
                    end
                end
            end
            default: st_next = smpb_pkg::ST_IDLE;
        endcase
        if (msg_valid && msg_ready) begin
            hdr_w_next[0] = ts[31:0];
            hdr_w_next[1] = ts[63:32];
            hdr_w_next[2] = idw;
            bytes_left_next = msg_info.length;
            seg_total = {1'b0, msg_info.length};
            if (csw_reg[smpb_pkg::CSW_TYPE_LSB +: smpb_pkg::CSW_TYPE_W] != smpb_pkg::TYPE_COMPLETE) begin
                if (long_bytes_reg > smpb_pkg::LONG_MAX_BYTES - 32'(seg_total)) begin
                    ev[smpb_pkg::IRQ_LONG_OVF] = 1'b1;
                    long_open_next = 1'b0;
                end else begin
                    long_bytes_next = long_bytes_reg + 32'(seg_total);
                end
            end
            if (msg_info.data_corrupt_flag || msg_info.protocol_fault_flag)
                ev[smpb_pkg::IRQ_ERR_MSG] = 1'b1;
            hw_idx_next = '0;
            st_next = smpb_pkg::ST_HDR;
        end
    end

    always_comb begin
        enable_next = enable_reg;
        mask_next = mask_reg;
        // hardware set wins over write-one clear
        sts_next = sts_reg | ev;
        if (reg_wr) begin
            if (reg_addr == smpb_pkg::REG_CTRL)
                enable_next = reg_wdata[0];
            if (reg_addr == smpb_pkg::REG_MASK)
                mask_next = reg_wdata[smpb_pkg::IRQ_W-1:0];
            if (reg_addr == smpb_pkg::REG_IRQ)
                sts_next = (sts_reg & ~reg_wdata[smpb_pkg::IRQ_W-1:0]) | ev;
        end
        rdata_next = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                smpb_pkg::REG_CTRL:   rdata_next = {31'h00000000, enable_reg};
                smpb_pkg::REG_STATUS: rdata_next = {12'h000, long_open_reg, seg_num_reg, st_reg};
                smpb_pkg::REG_IRQ:    rdata_next = {29'h00000000, sts_reg};
                smpb_pkg::REG_MASK:   rdata_next = {29'h00000000, mask_reg};
                smpb_pkg::REG_PKTS:   rdata_next = {16'h0000, pkts_reg};
                default:              rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_reg <= smpb_pkg::ST_IDLE;
            csw_reg <= '0;
            msgs_left_reg <= '0;
            hdr_cnt_reg <= '0;
            hw_idx_reg <= '0;
            hdr_w_reg <= '{default: '0};
            bytes_left_reg <= '0;
            have_lo_reg <= 1'b0;
            lo_byte_reg <= '0;
            seg_num_reg <= '0;
            long_bytes_reg <= '0;
            long_open_reg <= 1'b0;
            out_reg <= '0;
            ov_reg <= 1'b0;
            enable_reg <= 1'b0;
            sts_reg <= '0;
            mask_reg <= '0;
            pkts_reg <= '0;
            rdata_reg <= '0;
        end else begin
            st_reg <= st_next;
            csw_reg <= csw_next;
            msgs_left_reg <= msgs_left_next;
            hdr_cnt_reg <= hdr_cnt_next;
            hw_idx_reg <= hw_idx_next;
            hdr_w_reg <= hdr_w_next;
            bytes_left_reg <= bytes_left_next;
            have_lo_reg <= have_lo_next;
            lo_byte_reg <= lo_byte_next;
            seg_num_reg <= seg_num_next;
            long_bytes_reg <= long_bytes_next;
            long_open_reg <= long_open_next;
            out_reg <= out_next;
            ov_reg <= ov_next;
            enable_reg <= enable_next;
            sts_reg <= sts_next;
            mask_reg <= mask_next;
            pkts_reg <= pkts_next;
            rdata_reg <= rdata_next;
        end
    end

    AST_CSW_RSVD: assert property (@(posedge ref_clk) disable iff (reset)
        st_reg == smpb_pkg::ST_CSW_LO |-> csw_reg[31:18] == 14'h0000) else $error("reserved bits set");
    AST_CPL_TYPE: assert property (@(posedge ref_clk) disable iff (reset)
        start_valid && start_ready && !start_segmented && start_msg_count != 16'h0000
        && start_msg_count <= 16'(MAX_MSGS)
        |=> csw_reg[17:0] == {2'h0, $past(start_msg_count)}) else $error("complete word wrong");
    AST_SEG_FIRST: assert property (@(posedge ref_clk) disable iff (reset)
        start_valid && start_ready && start_segmented && start_seg_pos == smpb_pkg::TYPE_FIRST
        |=> seg_num_reg == 16'h0001 && csw_reg[17:16] == 2'h1) else $error("first segment wrong");
    AST_SEG_INC: assert property (@(posedge ref_clk) disable iff (reset)
        start_valid && start_ready && start_segmented && long_open_reg
        && start_seg_pos == smpb_pkg::TYPE_MIDDLE
        |=> seg_num_reg == $past(seg_num_reg) + 16'h0001) else $error("segment not incremented");
    AST_HDR_LEN: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(st_reg == smpb_pkg::ST_HDR) |-> hw_idx_reg == 3'h0) else $error("header not from start");
    AST_REL_FILL: assert property (@(posedge ref_clk) disable iff (reset)
        msg_valid && msg_ready && !packet_flags[smpb_pkg::FLAG_ABS] |=> hdr_w_reg[1][31:16] == 16'h0000)
        else $error("time fill not zero");
    AST_ID_FLAGS: assert property (@(posedge ref_clk) disable iff (reset)
        msg_valid && msg_ready |=> hdr_w_reg[2][31:30] ==
        {$past(msg_info.data_corrupt_flag), $past(msg_info.protocol_fault_flag)})
        else $error("id flags wrong");
    AST_PAD: assert property (@(posedge ref_clk) disable iff (reset)
        st_reg == smpb_pkg::ST_DATA && byte_valid && byte_ready && !have_lo_reg && bytes_left_reg == 16'h0001
        |=> out_reg.data[15:8] == smpb_pkg::FILLER_BYTE) else $error("odd byte not padded");
    AST_HDR_CNT: assert property (@(posedge ref_clk) disable iff (reset)
        out_valid && out_ready && out_word.last && csw_reg[17:16] == 2'h0
        |-> hdr_cnt_reg == csw_reg[15:0]) else $error("header count mismatch");
endmodule

`default_nettype wire

// ===== smpb_pkg.sv
package smpb_pkg;

    // channel specific word layout
    localparam int CSW_TYPE_LSB   = 16;
    localparam int CSW_TYPE_W     = 2;
    localparam int CSW_CNT_W      = 16;
    localparam int CSW_RSVD_W     = 14;
    localparam logic [1:0] TYPE_COMPLETE = 2'h0;
    localparam logic [1:0] TYPE_FIRST    = 2'h1;
    localparam logic [1:0] TYPE_LAST     = 2'h2;
    localparam logic [1:0] TYPE_MIDDLE   = 2'h3;

    // id word, time stamp and message body constants
    localparam int SUBCH_W   = 14;
    localparam int LEN_W     = 16;
    localparam int TIME_W    = 64;
    localparam int REL_W     = 48;
    localparam int FLAG_ABS  = 6;
    localparam int FLAG_FMT0 = 2;
    localparam int FLAG_FMT1 = 3;
    localparam logic [15:0] TIME_ZERO_FILL = 16'h0000;
    localparam logic [7:0]  FILLER_BYTE    = 8'h00;
    localparam logic [15:0] SEG_FIRST_NUM  = 16'h0001;
    localparam logic [31:0] LONG_MAX_BYTES = 32'hffffffff;

    // register map
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_IRQ    = 4'h2;
    localparam logic [3:0] REG_MASK   = 4'h3;
    localparam logic [3:0] REG_PKTS   = 4'h4;
    localparam int IRQ_W = 3;
    localparam int IRQ_PKT_DONE = 0;
    localparam int IRQ_ERR_MSG  = 1;
    localparam int IRQ_LONG_OVF = 2;

    // one message announcement
    typedef struct packed {
        logic [REL_W-1:0]   rel_time;
        logic [TIME_W-1:0]  abs_time;
        logic               data_corrupt_flag;
        logic               protocol_fault_flag;
        logic [SUBCH_W-1:0] subchannel;
        logic [LEN_W-1:0]   length;
    } smpb_msg_t;

    typedef struct packed {
        logic [15:0] data;
        logic        first;
        logic        last;
    } smpb_word_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CSW_LO, ST_CSW_HI, ST_HDR, ST_DATA, ST_DONE
    } smpb_state_t;

endpackage

// ===== smpb_partner.sv
`timescale 1ns/1ps
`default_nettype none
module smpb_partner (
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 slow,
    output logic                      byte_valid,
    input  wire logic                 byte_ready,
    output logic [7:0]                byte_data,
    input  wire smpb_pkg::smpb_word_t out_word,
    input  wire logic                 out_valid,
    output logic                      out_ready
);
    logic [7:0]           src_q [$];
    smpb_pkg::smpb_word_t got_q [$];

    initial begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
        out_ready = 1'b0;
    end

    // channel side hands bytes in order, stream side stalls when slow
    always @(posedge ref_clk) begin
        if (byte_valid && byte_ready) begin
            void'(src_q.pop_front());
        end
        if (out_valid && out_ready) begin
            got_q.push_back(out_word);
        end
        byte_valid <= (src_q.size() != 0);
        byte_data <= (src_q.size() != 0) ? src_q[0] : ~byte_data;
        out_ready <= reset ? 1'b0 : (slow ? ~out_ready : 1'b1);
    end
endmodule
`default_nettype wire

// ===== smpb_builder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module smpb_builder_tb_top;
    logic                 ref_clk;
    logic                 reset;
    logic [3:0]           reg_addr;
    logic [31:0]          reg_wdata;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [31:0]          reg_rdata;
    logic                 irq;
    logic [7:0]           packet_flags;
    logic                 start_valid;
    logic                 start_ready;
    logic                 start_segmented;
    logic [1:0]           start_seg_pos;
    logic [15:0]          start_msg_count;
    logic                 msg_valid;
    logic                 msg_ready;
    smpb_pkg::smpb_msg_t  msg_info;
    logic                 byte_valid;
    logic                 byte_ready;
    logic [7:0]           byte_data;
    smpb_pkg::smpb_word_t out_word;
    logic                 out_valid;
    logic                 out_ready;
    logic                 slow;
    smpb_pkg::smpb_word_t exp_q [$];
    int                   n_mismatch;
    int                   n_compared;
    int                   cyc;

    smpb_builder i_smpb_builder (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .packet_flags(packet_flags), .start_valid(start_valid), .start_ready(start_ready),
        .start_segmented(start_segmented), .start_seg_pos(start_seg_pos),
        .start_msg_count(start_msg_count), .msg_valid(msg_valid), .msg_ready(msg_ready),
        .msg_info(msg_info), .byte_valid(byte_valid), .byte_ready(byte_ready),
        .byte_data(byte_data), .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready));

    smpb_partner i_smpb_partner (.ref_clk(ref_clk), .reset(reset), .slow(slow),
        .byte_valid(byte_valid), .byte_ready(byte_ready), .byte_data(byte_data),
        .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop;
        if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check("reg_rdata", exp, reg_rdata);
    endtask

    task automatic push_exp(input logic [15:0] d);
        exp_q.push_back('{data: d, first: (exp_q.size() == 0), last: 1'b0});
    endtask

    task automatic start_pkt(input logic seg, input logic [1:0] pos, input logic [15:0] cnt,
                             input logic [15:0] csw_cnt);
        logic [31:0] csw;
        csw = {14'h0000, seg ? pos : smpb_pkg::TYPE_COMPLETE, csw_cnt};
        push_exp(csw[15:0]);
        push_exp(csw[31:16]);
        @(posedge ref_clk);
        start_valid <= 1'b1;
        start_segmented <= seg;
        start_seg_pos <= pos;
        start_msg_count <= cnt;
        do @(posedge ref_clk); while (start_ready !== 1'b1);
        start_valid <= 1'b0;
    endtask

    task automatic send_msg(input smpb_pkg::smpb_msg_t m, input logic [7:0] b0);
        logic [63:0] ts;
        logic [31:0] id;
        ts = packet_flags[smpb_pkg::FLAG_ABS] ? m.abs_time : {16'h0000, m.rel_time};
        id = {m.data_corrupt_flag, m.protocol_fault_flag, m.subchannel, m.length};
        for (int i = 0; i < 4; i++) push_exp(ts[16*i +: 16]);
        push_exp(id[15:0]);
        push_exp(id[31:16]);
        for (int i = 0; i < m.length; i += 2)
            push_exp({(i + 1 < m.length) ? b0 + 8'(i + 1) : smpb_pkg::FILLER_BYTE, b0 + 8'(i)});
        for (int i = 0; i < m.length; i++) i_smpb_partner.src_q.push_back(b0 + 8'(i));
        @(posedge ref_clk);
        msg_valid <= 1'b1;
        msg_info <= m;
        do @(posedge ref_clk); while (msg_ready !== 1'b1);
        msg_valid <= 1'b0;
    endtask

    task automatic end_pkt;
        exp_q[exp_q.size()-1].last = 1'b1;
        for (int i = 0; i < 3000 && i_smpb_partner.got_q.size() < exp_q.size(); i++) @(posedge ref_clk);
        check("word_count", 32'(exp_q.size()), 32'(i_smpb_partner.got_q.size()));
        foreach (exp_q[i]) check("out_word", 32'(exp_q[i]), 32'(i_smpb_partner.got_q[i]));
        exp_q.delete();
        i_smpb_partner.got_q.delete();
    endtask

    initial begin
        reset = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd, packet_flags} = '0;
        {start_valid, start_segmented, start_seg_pos, start_msg_count, msg_valid} = '0;
        msg_info = '0;
        slow = 1'b1;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        reg_read(smpb_pkg::REG_CTRL, 32'h0);
        check("start_ready", 32'h0, 32'(start_ready));
        reg_read(4'hf, 32'h0);
        reg_write(smpb_pkg::REG_MASK, 32'h0);
        reg_write(smpb_pkg::REG_CTRL, 32'h1);
        // two whole messages, odd length then empty, stalling sink
        start_pkt(1'b0, 2'h0, 16'h0002, 16'h0002);
        send_msg('{48'h1234_5678_9abc, 64'hffff_0000_1111_2222, 1'b1, 1'b0, 14'h0003, 16'h0003}, 8'h40);
        send_msg('{48'h0000_0000_0001, 64'h0, 1'b0, 1'b1, 14'h3fff, 16'h0000}, 8'h00);
        end_pkt;
        reg_read(smpb_pkg::REG_IRQ, 32'h3);
        check("irq", 32'h0, 32'(irq));
        reg_write(smpb_pkg::REG_MASK, 32'h1);
        @(posedge ref_clk);
        #1 check("irq", 32'h1, 32'(irq));
        reg_write(smpb_pkg::REG_IRQ, 32'h3);
        @(posedge ref_clk);
        #1 check("irq", 32'h0, 32'(irq));
        reg_read(smpb_pkg::REG_IRQ, 32'h0);
        // absolute stamp selected, free-running sink
        slow <= 1'b0;
        packet_flags <= 8'h4c;
        start_pkt(1'b0, 2'h0, 16'h0001, 16'h0001);
        send_msg('{48'haaaa_bbbb_cccc, 64'h0123_4567_89ab_cdef, 1'b0, 1'b0, 14'h0000, 16'h0004}, 8'h20);
        end_pkt;
        packet_flags <= 8'h00;
        // one long message in three segments
        for (int s = 0; s < 3; s++) begin
            start_pkt(1'b1, (s == 0) ? smpb_pkg::TYPE_FIRST : (s == 1) ? smpb_pkg::TYPE_MIDDLE
                      : smpb_pkg::TYPE_LAST, 16'h0001, 16'(s + 1));
            send_msg('{48'(s), 64'h0, 1'b0, 1'b0, 14'h0001, 16'(5 + s)}, 8'h80);
            end_pkt;
        end
        reg_read(smpb_pkg::REG_PKTS, 32'h5);
        reg_read(smpb_pkg::REG_STATUS, {12'h000, 1'b0, 16'h0003, 3'(smpb_pkg::ST_IDLE)});
        report_and_stop;
    end
endmodule
`default_nettype wire
